// ===== hw/serial_port.sv
`include "serial_port_defines.svh"
module serial_port (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       standby_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       dma_tx_wr_i,
  input  wire logic [7:0] dma_tx_data_i,
  input  wire logic       dma_rx_rd_i,
  input  wire logic       rxd_i,
  output logic            txd_o,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  output logic            tx_empty_irq_o,
  output logic            rx_full_irq_o,
  output logic            rx_error_irq_o,
  output logic            tx_done_irq_o
);
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [7:0] format_reg, next_format_reg;
  logic [7:0] rate_reg, next_rate_reg;
  logic [7:0] ctrl_reg, next_ctrl_reg;
  logic [7:0] tx_holding, next_tx_holding;
  logic [7:0] stat_reg, next_stat_reg;
  logic [7:0] rx_holding, next_rx_holding;
  logic [7:0] seen_one, next_seen_one;
  logic [7:0] next_rdata;
  logic       brg_tick, rxd_s, sck_s, sck_d, next_sck_d;
  logic       sync_mode, ext_clk, os_tick;
  logic [3:0] tx_os, next_tx_os, rx_os, next_rx_os;
  logic [11:0] tx_shifter, next_tx_shifter;
  logic [3:0] tx_bits, next_tx_bits;
  logic [10:0] rx_shifter, next_rx_shifter;
  logic [3:0] rx_bits, next_rx_bits;
  logic       next_txd, next_sck_o, next_sck_oe;
  logic       sck_gen, next_sck_gen;
  logic       tx_bit_edge, rx_sample;
  serial_port_pkg::tx_state_type tx_state, next_tx_state;
  serial_port_pkg::rx_state_type rx_state, next_rx_state;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  baud_gen u_brg (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .sel_i   (serial_port_pkg::prescale_type'(format_reg[1:0])),
    .rate_i  (rate_reg),
    .tick_o  (brg_tick)
  );
  pin_sync u_rxd (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(rxd_i),
                  .level_o(rxd_s));
  pin_sync u_sck (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(sck_i),
                  .level_o(sck_s));

  assign sync_mode = format_reg[`FM_SYNC];
  assign ext_clk   = ctrl_reg[`CT_EXT_CLK];

  // Bit timing and clock pin
  always_comb begin
    next_sck_d   = sck_s;
    next_sck_gen = sck_gen;
    next_tx_os   = tx_os;
    next_rx_os   = rx_os;
    tx_bit_edge  = 1'b0;
    rx_sample    = 1'b0;
    // external 16x clock counts rising pin edges
    os_tick = ext_clk ? (sck_s && !sck_d) : brg_tick;
    if (sync_mode) begin
      // bit clock is the internal tick or the pin
      if (ext_clk) begin
        tx_bit_edge = !sck_s && sck_d;
        rx_sample   = sck_s && !sck_d;
      end else if (brg_tick) begin
        next_sck_gen = !sck_gen;
        tx_bit_edge  = sck_gen;
        rx_sample    = !sck_gen;
      end
    end else if (os_tick) begin
      next_tx_os  = tx_os + 4'h1;
      next_rx_os  = rx_os + 4'h1;
      tx_bit_edge = (tx_os == 4'hF);
      rx_sample   = (rx_os == 4'h7);
    end
    // Receive phase restarts while waiting for a start bit
    if (rx_state == serial_port_pkg::RX_IDLE) begin
      next_rx_os = 4'h0;
    end
    next_sck_oe = 1'b0;
    next_sck_o  = 1'b1;
    if (sync_mode && !ext_clk) begin
      next_sck_oe = 1'b1;
      next_sck_o  = (tx_state == serial_port_pkg::TX_SHIFT) ? sck_gen : 1'b1;
    end else if (!sync_mode && !ext_clk && ctrl_reg[`CT_SCK_OUT]) begin
      next_sck_oe = 1'b1;
      next_sck_o  = tx_os[3];
    end
  end

  // Registers, flags and both shifters
  always_comb begin
    logic       wr_stat, rd_stat, tx_clear, par;
    logic       mp_bit, stop_ok, par_ok, rx_done;
    logic [7:0] rdat;
    next_format_reg = format_reg;
    next_rate_reg   = rate_reg;
    next_ctrl_reg   = ctrl_reg;
    next_tx_holding = tx_holding;
    next_stat_reg   = stat_reg;
    next_rx_holding = rx_holding;
    next_seen_one   = seen_one;
    next_tx_state   = tx_state;
    next_tx_shifter = tx_shifter;
    next_tx_bits    = tx_bits;
    next_rx_state   = rx_state;
    next_rx_shifter = rx_shifter;
    next_rx_bits    = rx_bits;
    next_txd        = txd_o;
    next_rdata      = 8'h00;
    wr_stat  = wr_i && addr_i == `SP_STAT_ADDR;
    rd_stat  = rd_i && addr_i == `SP_STAT_ADDR;
    tx_clear = 1'b0;
    rx_done  = 1'b0;
    mp_bit   = 1'b0;
    stop_ok  = 1'b1;
    par_ok   = 1'b1;
    rdat     = 8'h00;
    par      = 1'b0;
    if (rd_i) begin
      if (addr_i == `SP_FORMAT_ADDR) begin
        next_rdata = format_reg;
      end else if (addr_i == `SP_RATE_ADDR) begin
        next_rdata = rate_reg;
      end else if (addr_i == `SP_CTRL_ADDR) begin
        next_rdata = ctrl_reg;
      end else if (addr_i == `SP_TXH_ADDR) begin
        next_rdata = tx_holding;
      end else if (addr_i == `SP_STAT_ADDR) begin
        next_rdata = stat_reg;
      end else if (addr_i == `SP_RXH_ADDR) begin
        next_rdata = rx_holding;
      end
    end
    if (wr_i) begin
      if (addr_i == `SP_FORMAT_ADDR) begin
        next_format_reg = wdata_i;
      end else if (addr_i == `SP_RATE_ADDR) begin
        next_rate_reg = wdata_i;
      end else if (addr_i == `SP_CTRL_ADDR) begin
        next_ctrl_reg = wdata_i;
      end else if (addr_i == `SP_TXH_ADDR) begin
        next_tx_holding = wdata_i;
      end
    end
    if (rd_stat) begin
      next_seen_one = seen_one | stat_reg;
    end
    // zero clears only a flag read as 1
    if (wr_stat) begin
      for (int i = 3; i < 8; i++) begin
        if (!wdata_i[i] && seen_one[i]) begin
          next_stat_reg[i] = 1'b0;
          next_seen_one[i] = 1'b0;
        end
      end
      // only the transmit address bit is writable
      next_stat_reg[`ST_TX_ADDR] = wdata_i[`ST_TX_ADDR];
    end
    // DMA write fills holding and clears empty
    if (dma_tx_wr_i) begin
      next_tx_holding              = dma_tx_data_i;
      next_stat_reg[`ST_TX_EMPTY]  = 1'b0;
    end
    tx_clear = stat_reg[`ST_TX_EMPTY] && !next_stat_reg[`ST_TX_EMPTY];
    if (tx_clear) begin
      next_stat_reg[`ST_TX_DONE] = 1'b0;
    end
    if (dma_rx_rd_i) begin
      next_stat_reg[`ST_RX_FULL] = 1'b0;
    end

    // transmitter runs once empty flag is clear
    case (tx_state)
      serial_port_pkg::TX_IDLE: begin
        next_txd = 1'b1;
        if (ctrl_reg[`CT_TX_EN] && !stat_reg[`ST_TX_EMPTY]) begin
          next_tx_state = serial_port_pkg::TX_LOAD;
        end
      end
      serial_port_pkg::TX_LOAD: begin
        par = ^tx_holding ^ format_reg[`FM_PAR_ODD];
        if (format_reg[`FM_SEVEN] && !sync_mode) begin
          par = ^tx_holding[6:0] ^ format_reg[`FM_PAR_ODD];
        end
        if (sync_mode) begin
          next_tx_shifter = {4'hF, tx_holding};
          next_tx_bits    = 4'h8;
        end else begin
          next_tx_shifter = {3'h7, tx_holding, 1'b0};
          next_tx_bits    = 4'hA;
          if (format_reg[`FM_SEVEN]) begin
            next_tx_shifter[8] = 1'b1;
            next_tx_bits       = 4'h9;
          end
          if (format_reg[`FM_MULTI] || format_reg[`FM_PAR_EN]) begin
            next_tx_shifter[next_tx_bits - 4'h1] = format_reg[`FM_MULTI] ?
              stat_reg[`ST_TX_ADDR] : par;
            next_tx_bits = next_tx_bits + 4'h1;
          end
          next_tx_bits = next_tx_bits + {3'h0, format_reg[`FM_TWO_STOP]};
        end
        next_stat_reg[`ST_TX_EMPTY] = 1'b1;
        next_tx_state = serial_port_pkg::TX_SHIFT;
      end
      default: begin
        if (tx_bit_edge) begin
          next_txd        = tx_shifter[0];
          next_tx_shifter = {1'b1, tx_shifter[11:1]};
          next_tx_bits    = tx_bits - 4'h1;
          if (tx_bits == 4'h1) begin
            if (!stat_reg[`ST_TX_EMPTY] && ctrl_reg[`CT_TX_EN]) begin
              next_tx_state = serial_port_pkg::TX_LOAD;
            end else begin
              // last bit out with nothing waiting
              next_stat_reg[`ST_TX_DONE] = 1'b1;
              next_tx_state = serial_port_pkg::TX_IDLE;
            end
          end
        end
      end
    endcase

    // start bit or first sync-mode sample edge (pin or internal tick) begins reception
    case (rx_state)
      serial_port_pkg::RX_IDLE: begin
        next_rx_bits = 4'h0;
        if (ctrl_reg[`CT_RX_ON]) begin
          if (sync_mode && rx_sample) begin
            next_rx_shifter = {rxd_s, rx_shifter[10:1]};
            next_rx_bits    = 4'h1;
            next_rx_state   = serial_port_pkg::RX_SHIFT;
          end else if (!sync_mode && !rxd_s) begin
            next_rx_state = serial_port_pkg::RX_SHIFT;
          end
        end
      end
      serial_port_pkg::RX_SHIFT: begin
        if (!ctrl_reg[`CT_RX_ON]) begin
          next_rx_state = serial_port_pkg::RX_IDLE;
        end else if (rx_sample) begin
          next_rx_shifter = {rxd_s, rx_shifter[10:1]};
          next_rx_bits    = rx_bits + 4'h1;
          if (next_rx_bits == (sync_mode ? 4'h8 : 4'h2 +
              (format_reg[`FM_SEVEN] ? 4'h7 : 4'h8) +
              {3'h0, format_reg[`FM_MULTI] | format_reg[`FM_PAR_EN]})) begin
            next_rx_state = serial_port_pkg::RX_DONE;
          end
        end
      end
      default: begin
        rx_done       = 1'b1;
        next_rx_state = serial_port_pkg::RX_IDLE;
      end
    endcase
    if (rx_done) begin
      if (sync_mode) begin
        rdat = rx_shifter[10:3];
      end else begin
        rdat    = format_reg[`FM_SEVEN] ? {1'b0, rx_shifter[9:3]} :
                  rx_shifter[9:2];
        stop_ok = rx_shifter[10];
        if (format_reg[`FM_MULTI] || format_reg[`FM_PAR_EN]) begin
          rdat    = format_reg[`FM_SEVEN] ? {1'b0, rx_shifter[8:2]} :
                    rx_shifter[8:1];
          mp_bit  = rx_shifter[9];
          par_ok  = format_reg[`FM_MULTI] ||
                    ((^rdat ^ mp_bit) == format_reg[`FM_PAR_ODD]);
        end
        if (format_reg[`FM_SEVEN] || format_reg[`FM_MULTI] ||
            format_reg[`FM_PAR_EN]) begin
          stop_ok = rx_shifter[10];
        end
      end
      if (!sync_mode && format_reg[`FM_MULTI] &&
          ctrl_reg[`CT_ADDR_WAIT] && !mp_bit) begin
        rdat = rx_holding;
      end else begin
        if (!sync_mode && format_reg[`FM_MULTI]) begin
          next_stat_reg[`ST_RX_ADDR]  = mp_bit;
          next_ctrl_reg[`CT_ADDR_WAIT] = 1'b0;
        end
        if (stat_reg[`ST_RX_FULL]) begin
          next_stat_reg[`ST_OVERRUN] = 1'b1;
        end else if (!stop_ok || !par_ok) begin
          next_rx_holding            = rdat;
          next_stat_reg[`ST_FRAMING] = next_stat_reg[`ST_FRAMING] | !stop_ok;
          next_stat_reg[`ST_PARITY]  = next_stat_reg[`ST_PARITY] | !par_ok;
        end else begin
          next_rx_holding            = rdat;
          next_stat_reg[`ST_RX_FULL] = 1'b1;
        end
      end
    end
    if (!ctrl_reg[`CT_TX_EN]) begin
      next_stat_reg[`ST_TX_EMPTY] = 1'b1;
      next_stat_reg[`ST_TX_DONE]  = 1'b1;
      next_tx_state               = serial_port_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      format_reg <= `SP_FORMAT_RST;
      rate_reg   <= `SP_RATE_RST;
      ctrl_reg   <= `SP_CTRL_RST;
      tx_holding <= `SP_TXH_RST;
      stat_reg   <= `SP_STAT_RST;
      rx_holding <= `SP_RXH_RST;
      seen_one   <= 8'h00;
      rdata_o    <= 8'h00;
      tx_state   <= serial_port_pkg::TX_IDLE;
      rx_state   <= serial_port_pkg::RX_IDLE;
      tx_shifter <= 12'hFFF;
      rx_shifter <= 11'h000;
      tx_bits    <= 4'h0;
      rx_bits    <= 4'h0;
      tx_os      <= 4'h0;
      rx_os      <= 4'h0;
      sck_d      <= 1'b1;
      sck_gen    <= 1'b1;
      txd_o      <= 1'b1;
      sck_o      <= 1'b1;
      sck_oe_o   <= 1'b0;
    end else if (standby_i) begin
      format_reg <= `SP_FORMAT_RST;
      rate_reg   <= `SP_RATE_RST;
      ctrl_reg   <= `SP_CTRL_RST;
      tx_holding <= `SP_TXH_RST;
      stat_reg   <= `SP_STAT_RST;
      rx_holding <= `SP_RXH_RST;
      seen_one   <= 8'h00;
      rdata_o    <= 8'h00;
      tx_state   <= serial_port_pkg::TX_IDLE;
      rx_state   <= serial_port_pkg::RX_IDLE;
      tx_shifter <= 12'hFFF;
      rx_shifter <= 11'h000;
      tx_bits    <= 4'h0;
      rx_bits    <= 4'h0;
      tx_os      <= 4'h0;
      rx_os      <= 4'h0;
      sck_d      <= sck_s;
      sck_gen    <= 1'b1;
      txd_o      <= 1'b1;
      sck_o      <= 1'b1;
      sck_oe_o   <= 1'b0;
    end else begin
      format_reg <= next_format_reg;
      rate_reg   <= next_rate_reg;
      ctrl_reg   <= next_ctrl_reg;
      tx_holding <= next_tx_holding;
      stat_reg   <= next_stat_reg;
      rx_holding <= next_rx_holding;
      seen_one   <= next_seen_one;
      rdata_o    <= next_rdata;
      tx_state   <= next_tx_state;
      rx_state   <= next_rx_state;
      tx_shifter <= next_tx_shifter;
      rx_shifter <= next_rx_shifter;
      tx_bits    <= next_tx_bits;
      rx_bits    <= next_rx_bits;
      tx_os      <= next_tx_os;
      rx_os      <= next_rx_os;
      sck_d      <= next_sck_d;
      sck_gen    <= next_sck_gen;
      txd_o      <= next_txd;
      sck_o      <= next_sck_o;
      sck_oe_o   <= next_sck_oe;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_irq_o <= 1'b0;
      rx_full_irq_o  <= 1'b0;
      rx_error_irq_o <= 1'b0;
      tx_done_irq_o  <= 1'b0;
    end else begin
      tx_empty_irq_o <= next_stat_reg[`ST_TX_EMPTY] &
                        next_ctrl_reg[`CT_TXE_IE] & !standby_i;
      rx_full_irq_o  <= next_stat_reg[`ST_RX_FULL] &
                        next_ctrl_reg[`CT_RX_IE] & !standby_i;
      rx_error_irq_o <= (|next_stat_reg[5:3]) &
                        next_ctrl_reg[`CT_RX_IE] & !standby_i;
      tx_done_irq_o  <= next_stat_reg[`ST_TX_DONE] &
                        next_ctrl_reg[`CT_TXD_IE] & !standby_i;
    end
  end

  logic rx_done_w;
  assign rx_done_w = rx_state == serial_port_pkg::RX_DONE;

  AST_RESET_STAT: assert property (@(posedge clk_i)
    $rose(rst_n) |-> stat_reg == `SP_STAT_RST)
    else $error("status not 0x84 after reset");
  AST_TX_OFF_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n)
    !ctrl_reg[`CT_TX_EN] && !standby_i |=> stat_reg[`ST_TX_EMPTY])
    else $error("empty flag not held while disabled");
  AST_TXE_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n)
    ##1 tx_empty_irq_o == (stat_reg[7] & ctrl_reg[7]))
    else $error("transmit-empty request mismatch");
  AST_RX_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n)
    ##1 rx_full_irq_o == (stat_reg[6] & ctrl_reg[6]))
    else $error("receive-full request mismatch");
  AST_NO_SET_BY_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == `SP_STAT_ADDR && !stat_reg[`ST_OVERRUN] && !rx_done_w
    |=> !stat_reg[`ST_OVERRUN])
    else $error("write set a flag");
  AST_TXD_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n)
    ##1 tx_done_irq_o == (stat_reg[2] & ctrl_reg[2]))
    else $error("transmit-end request mismatch");
  AST_ERR_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n)
    ##1 rx_error_irq_o == ((|stat_reg[5:3]) & ctrl_reg[6]))
    else $error("receive-error request mismatch");
  AST_RO_DONE: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == `SP_STAT_ADDR && !stat_reg[2] && !standby_i &&
    tx_state != serial_port_pkg::TX_SHIFT && ctrl_reg[5]
    |=> !stat_reg[2])
    else $error("transmit-end written");
endmodule

// ===== hw/serial_port_defines.svh
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
// Register indices on the plain register port
`define SP_FORMAT_ADDR   3'h0
`define SP_RATE_ADDR     3'h1
`define SP_CTRL_ADDR     3'h2
`define SP_TXH_ADDR      3'h3
`define SP_STAT_ADDR     3'h4
`define SP_RXH_ADDR      3'h5
// Reset values
`define SP_FORMAT_RST    8'h00
`define SP_RATE_RST      8'hFF
`define SP_CTRL_RST      8'h00
`define SP_TXH_RST       8'hFF
`define SP_STAT_RST      8'h84
`define SP_RXH_RST       8'h00
// Control field positions
`define CT_TXE_IE        7
`define CT_RX_IE         6
`define CT_TX_EN         5
`define CT_RX_ON         4
`define CT_ADDR_WAIT     3
`define CT_TXD_IE        2
`define CT_EXT_CLK       1
`define CT_SCK_OUT       0
// Status field positions
`define ST_TX_EMPTY      7
`define ST_RX_FULL       6
`define ST_OVERRUN       5
`define ST_FRAMING       4
`define ST_PARITY        3
`define ST_TX_DONE       2
`define ST_RX_ADDR       1
`define ST_TX_ADDR       0
// Format field positions
`define FM_SYNC          7
`define FM_SEVEN         6
`define FM_PAR_EN        5
`define FM_PAR_ODD       4
`define FM_TWO_STOP      3
`define FM_MULTI         2
// Oversampling in asynchronous mode
`define SP_OVERSAMPLE    16
`endif

// ===== hw/serial_port_pkg.sv
package serial_port_pkg;
  typedef enum logic [1:0] {
    PRESCALE_DIV4,
    PRESCALE_DIV16,
    PRESCALE_DIV64,
    PRESCALE_DIV256
  } prescale_type;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LOAD,
    TX_SHIFT
  } tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_SHIFT,
    RX_DONE
  } rx_state_type;
endpackage

// ===== hw/baud_gen.sv
`include "serial_port_defines.svh"
module baud_gen (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire serial_port_pkg::prescale_type sel_i,
  input  wire logic [7:0]                  rate_i,
  output logic                             tick_o
);
  logic [7:0] pre;
  logic [7:0] next_pre;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       pre_hit;
  logic       next_tick;

  always_comb begin
    case (sel_i)
      serial_port_pkg::PRESCALE_DIV4:  pre_hit = (pre[1:0] == 2'h3);
      serial_port_pkg::PRESCALE_DIV16: pre_hit = (pre[3:0] == 4'hF);
      serial_port_pkg::PRESCALE_DIV64: pre_hit = (pre[5:0] == 6'h3F);
      default:                         pre_hit = (pre == 8'hFF);
    endcase
    next_pre  = pre + 8'h01;
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (pre_hit) begin
      if (cnt >= rate_i) begin
        next_cnt  = 8'h00;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre    <= 8'h00;
      cnt    <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      pre    <= next_pre;
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

// ===== hw/pin_sync.sv
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] stage;
  logic       next_level;

  // Change accepted when second and third stage agree
  always_comb begin
    next_level = level_o;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage   <= 3'h7;
      level_o <= 1'b1;
    end else begin
      stage   <= {stage[1:0], pin_i};
      level_o <= next_level;
    end
  end
endmodule

// ===== verification/serial_peer.sv
module serial_peer (
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic sck_out_i,
  input  wire logic sck_oe_i,
  output logic      rxd_o,
  output logic      sck_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_o = 1'b1;
  always @(posedge clk_i) begin
    rxd_o <= txd_i;
  end
  // Pull-up holds the clock pin when undriven
  assign sck_line_o = sck_oe_i ? sck_out_i : 1'b1;
endmodule

// ===== verification/serial_port_control_status_tb.sv
`include "serial_port_defines.svh"
module serial_port_control_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, arst_n, standby, wr, rd, dma_wr, dma_rd;
  logic       txd, rxd, sck_out, sck_oe, sck_line;
  logic       irq_te, irq_rf, irq_re, irq_td;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, dma_data, d, b;
  int         num_errors;
  int         checked;
  serial_port u_serial_port (
    .clk_i(clk), .arst_n_i(arst_n), .standby_i(standby), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .dma_tx_wr_i(dma_wr), .dma_tx_data_i(dma_data), .dma_rx_rd_i(dma_rd),
    .rxd_i(rxd), .txd_o(txd), .sck_i(sck_line), .sck_o(sck_out),
    .sck_oe_o(sck_oe), .tx_empty_irq_o(irq_te), .rx_full_irq_o(irq_rf),
    .rx_error_irq_o(irq_re), .tx_done_irq_o(irq_td));
  serial_peer u_serial_peer (
    .clk_i(clk), .txd_i(txd), .sck_out_i(sck_out), .sck_oe_i(sck_oe),
    .rxd_o(rxd), .sck_line_o(sck_line));
  function automatic logic [7:0] stat_exp(logic e, logic f, logic t);
    return {e, f, 3'h0, t, 2'h0};
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask
  task automatic irq_chk(input logic [7:0] e);
    repeat (2) @(posedge clk);
    #1 chk({4'h0, irq_te, irq_rf, irq_re, irq_td}, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    {arst_n, standby, wr, rd, dma_wr, dma_rd} = '0;
    {addr, wdata, dma_data, d} = '0;
    void'($urandom(32'h8a21f1be));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`SP_CTRL_ADDR, `SP_CTRL_RST);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b0, 1'b1));
    rd_chk(3'h6, 8'h00);
    wr_reg(`SP_STAT_ADDR, 8'h00);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b0, 1'b1));
    wr_reg(`SP_RATE_ADDR, 8'h00);
    wr_reg(`SP_FORMAT_ADDR, 8'h00);
    wr_reg(`SP_CTRL_ADDR, 8'h30);
    b = 8'($urandom());
    wr_reg(`SP_TXH_ADDR, b);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b0, 1'b1));
    wr_reg(`SP_STAT_ADDR, 8'h00);
    wr_reg(`SP_STAT_ADDR, 8'h04);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b0, 1'b0));
    for (int i = 0; i < 1000 && d[6] !== 1'b1; i++)
      rd_reg(`SP_STAT_ADDR, d);
    repeat (200) @(posedge clk);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b1, 1'b1));
    rd_chk(`SP_RXH_ADDR, b);
    wr_reg(`SP_CTRL_ADDR, 8'h44);
    irq_chk(8'h05);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b1, 1'b1));
    wr_reg(`SP_CTRL_ADDR, 8'hC4);
    irq_chk(8'h0D);
    @(posedge clk);
    dma_rd <= 1'b1;
    @(posedge clk);
    dma_rd <= 1'b0;
    irq_chk(8'h09);
    wr_reg(`SP_CTRL_ADDR, 8'h20);
    @(posedge clk);
    dma_data <= 8'($urandom());
    dma_wr   <= 1'b1;
    @(posedge clk);
    dma_wr <= 1'b0;
    rd_chk(`SP_TXH_ADDR, dma_data);
    rd_chk(`SP_STAT_ADDR, stat_exp(1'b1, 1'b0, 1'b0));
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd_chk(`SP_CTRL_ADDR, `SP_CTRL_RST);
    rd_chk(`SP_STAT_ADDR, `SP_STAT_RST);
    irq_chk(8'h00);
    end_sim();
  end
endmodule
